// File: verilog/dual_channel_offset_gain_trim.sv
// Two-channel offset and gain trim datapath with its trim registers.
// Assumes codes synchronous to CLK_SYS and a single-cycle register port.
`timescale 1ns/1ps
`default_nettype none
`include "trim_defs.svh"

// Contract
// - Offset on: output is trim plus code
// - Offset trim is 24-bit two's complement
// - Offset off: trim ignored, contents kept
// - Gain trim is signed fraction, minus one up
// - Gain on: code times one plus trim
// - Gain trim LSB weighs two to minus 23
// - Effective multiplier spans zero to nearly two
// - Gain off: trim ignored, contents kept
// - Tempco trim resets to 0x42, read/write
// - Offset enable both channels, no added delay
// - Gain enable delays data by 24 cycles
module dual_channel_offset_gain_trim (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // Register port
  input wire logic [`TRIM_ADDR_W-1:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [23:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [23:0] REG_RDATA,
  output logic REG_RVALID,
  // Correction enables
  input wire logic OFFSET_CORRECTION_ENABLE,
  input wire logic GAIN_CORRECTION_ENABLE,
  // Raw codes in
  input wire logic [23:0] CH0_CODE,
  input wire logic [23:0] CH1_CODE,
  input wire logic IN_VALID,
  output logic IN_READY,
  // Corrected codes out
  output logic [23:0] OUT_CH0,
  output logic [23:0] OUT_CH1,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  // Reference tempco trim
  output logic [7:0] REF_TEMPCO_TRIM
);
  localparam int DLY = `TRIM_GAIN_DELAY_CYC;

  trim_pkg::code_t off0, off1, gain0, gain1;
  trim_pkg::code_t next_off0, next_off1, next_gain0, next_gain1;
  logic [7:0] next_tempco;
  logic [23:0] next_rdata;
  logic next_rvalid;

  // Clamp rather than wrap; a wrapped code flips sign in metering sums
  function automatic trim_pkg::code_t sat24(input logic signed [25:0] v);
    if (v > $signed({2'b00, `TRIM_CODE_MAX})) return `TRIM_CODE_MAX;
    if (v < $signed({2'b11, `TRIM_CODE_MIN})) return `TRIM_CODE_MIN;
    return v[23:0];
  endfunction : sat24

  function automatic trim_pkg::code_t add_offset(input trim_pkg::code_t x, input trim_pkg::code_t o);
    return sat24(26'($signed(x)) + 26'($signed(o)));
  endfunction : add_offset

  function automatic trim_pkg::code_t apply_gain(input trim_pkg::code_t x, input trim_pkg::code_t g);
    logic [24:0] m;
    logic signed [49:0] p;
    m = 25'(`TRIM_GAIN_UNITY + 25'($signed(g)));
    p = 50'($signed(x)) * 50'($signed({1'b0, m}));
    p = p >>> `TRIM_GAIN_SHIFT;
    return sat24(p[25:0]);
  endfunction : apply_gain

  // Register file
  always_comb begin
    next_off0 = off0;
    next_off1 = off1;
    next_gain0 = gain0;
    next_gain1 = gain1;
    next_tempco = REF_TEMPCO_TRIM;
    // Enables never touch stored trims
    if (REG_WR) begin
      unique case (REG_ADDR)
        `TRIM_ADDR_OFF_CH0: next_off0 = REG_WDATA;
        `TRIM_ADDR_OFF_CH1: next_off1 = REG_WDATA;
        `TRIM_ADDR_GAIN_CH0: next_gain0 = REG_WDATA;
        `TRIM_ADDR_GAIN_CH1: next_gain1 = REG_WDATA;
        `TRIM_ADDR_TEMPCO: next_tempco = REG_WDATA[7:0];
        default: ;
      endcase
    end
    next_rvalid = REG_RD;
    next_rdata = `TRIM_RDATA_ZERO;
    if (REG_RD) begin
      unique case (REG_ADDR)
        `TRIM_ADDR_OFF_CH0: next_rdata = off0;
        `TRIM_ADDR_OFF_CH1: next_rdata = off1;
        `TRIM_ADDR_GAIN_CH0: next_rdata = gain0;
        `TRIM_ADDR_GAIN_CH1: next_rdata = gain1;
        `TRIM_ADDR_TEMPCO: next_rdata = {`TRIM_TEMPCO_PAD, REF_TEMPCO_TRIM};
        default: next_rdata = `TRIM_RDATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      off0 <= `TRIM_RST_OFF;
      off1 <= `TRIM_RST_OFF;
      gain0 <= `TRIM_RST_GAIN;
      gain1 <= `TRIM_RST_GAIN;
      REF_TEMPCO_TRIM <= `TRIM_RST_TEMPCO;
      REG_RDATA <= `TRIM_RDATA_ZERO;
      REG_RVALID <= 1'b0;
    end else begin
      off0 <= next_off0;
      off1 <= next_off1;
      gain0 <= next_gain0;
      gain1 <= next_gain1;
      REF_TEMPCO_TRIM <= next_tempco;
      REG_RDATA <= next_rdata;
      REG_RVALID <= next_rvalid;
    end
  end

  // Datapath: entry stage, then a fixed delay line used only in gain mode
  logic accept;
  trim_pkg::code_t ofs0, ofs1;
  trim_pkg::pair_t next_s0_data, s0_data;
  logic s0_valid, s0_gain, next_s0_valid, next_s0_gain;
  trim_pkg::pair_t dly [DLY];
  trim_pkg::pair_t next_dly [DLY];
  logic [DLY-1:0] dvalid, next_dvalid;
  logic byp_wr, dly_wr, fifo_wr, fifo_in_ready;
  trim_pkg::pair_t wr_data;
  trim_pkg::count_t inflight, next_inflight;
  logic [5:0] fifo_count;
  logic gain_pending, next_in_ready;

  always_comb begin
    accept = IN_VALID && IN_READY;
    // One enable steers both channels, combinational so no added latency
    ofs0 = OFFSET_CORRECTION_ENABLE ? add_offset(CH0_CODE, off0) : CH0_CODE;
    ofs1 = OFFSET_CORRECTION_ENABLE ? add_offset(CH1_CODE, off1) : CH1_CODE;
    // Gain follows offset; trims ignored while disabled
    next_s0_data = GAIN_CORRECTION_ENABLE ? {apply_gain(ofs1, gain1), apply_gain(ofs0, gain0)}
                                          : {ofs1, ofs0};
    next_s0_valid = accept;
    next_s0_gain = GAIN_CORRECTION_ENABLE;
    next_dly[0] = s0_data;
    next_dvalid[0] = s0_valid && s0_gain;
    for (int i = 1; i < DLY; i++) begin
      next_dly[i] = dly[i-1];
      next_dvalid[i] = dvalid[i-1];
    end
    byp_wr = s0_valid && !s0_gain;
    dly_wr = dvalid[DLY-1];
    fifo_wr = byp_wr || dly_wr;
    wr_data = dly_wr ? dly[DLY-1] : s0_data;
    next_inflight = trim_pkg::count_t'(inflight + trim_pkg::count_t'(accept) - trim_pkg::count_t'(fifo_wr));
    // A bypass word must not overtake or collide with delayed words
    gain_pending = (|dvalid) || (s0_valid && s0_gain) || (accept && GAIN_CORRECTION_ENABLE);
    // Credit covers every word still in flight, so the FIFO never overflows
    next_in_ready = fifo_in_ready && !(!GAIN_CORRECTION_ENABLE && gain_pending)
                    && (trim_pkg::count_t'(fifo_count) + inflight + trim_pkg::count_t'(accept)
                        < trim_pkg::count_t'(`TRIM_FIFO_DEPTH));
  end

  always_ff @(posedge CLK_SYS) begin
    dly <= next_dly;
    s0_data <= next_s0_data;
    if (!RESETN) begin
      s0_valid <= 1'b0;
      s0_gain <= 1'b0;
      dvalid <= '0;
      inflight <= '0;
      IN_READY <= 1'b0;
    end else begin
      s0_valid <= next_s0_valid;
      s0_gain <= next_s0_gain;
      dvalid <= next_dvalid;
      inflight <= next_inflight;
      IN_READY <= next_in_ready;
    end
  end

  sample_fifo #(
    .WIDTH(`TRIM_PAIR_W),
    .DEPTH(`TRIM_FIFO_DEPTH)
  ) u_out_fifo (
    .clk(CLK_SYS),
    .resetn(RESETN),
    .in_valid(fifo_wr),
    .in_ready(fifo_in_ready),
    .in_data(wr_data),
    .out_valid(OUT_VALID),
    .out_ready(OUT_READY),
    .out_data({OUT_CH1, OUT_CH0}),
    .count(fifo_count)
  );

  // Plain wrapped sum; the check trusts it only where no clamp applies
  trim_pkg::code_t sum0;
  logic sum0_fits;
  assign sum0 = trim_pkg::code_t'(CH0_CODE + off0);
  assign sum0_fits = (CH0_CODE[23] != off0[23]) || (sum0[23] == CH0_CODE[23]);

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  sequence acc_gain_s;
    accept && GAIN_CORRECTION_ENABLE;
  endsequence
  sequence acc_plain_s;
    accept && !GAIN_CORRECTION_ENABLE;
  endsequence

  gain_delay_a: assert property (acc_gain_s |-> ##25 dly_wr)
    else $error("gain sample not written 24 cycles late");
  plain_latency_a: assert property (acc_plain_s |-> ##1 (byp_wr && !dly_wr))
    else $error("bypass sample latency wrong");
  offset_sum_a: assert property (acc_plain_s ##0 OFFSET_CORRECTION_ENABLE && sum0_fits |=>
      wr_data[23:0] == $past(sum0))
    else $error("offset sum wrong");
  offset_ignore_a: assert property (acc_plain_s ##0 !OFFSET_CORRECTION_ENABLE |=>
      wr_data[23:0] == $past(CH0_CODE) && wr_data[47:24] == $past(CH1_CODE))
    else $error("offset applied while disabled");
  trim_hold_a: assert property (!REG_WR |=> $stable(off0) && $stable(off1) && $stable(gain0) && $stable(gain1))
    else $error("trim changed without a write");
  gain_path_a: assert property (dly_wr |-> wr_data == $past(next_s0_data, 25))
    else $error("gain result corrupted in delay line");
  sat_high_a: assert property (acc_plain_s ##0 OFFSET_CORRECTION_ENABLE && !CH0_CODE[23] && !off0[23]
      && (24'(CH0_CODE + off0) >= `TRIM_CODE_MIN) |=> wr_data[23:0] == `TRIM_CODE_MAX)
    else $error("positive overflow not clamped");
  tempco_reset_a: assert property (@(posedge CLK_SYS) disable iff (1'b0)
      !RESETN |=> REF_TEMPCO_TRIM == `TRIM_RST_TEMPCO)
    else $error("tempco trim reset value wrong");
  tempco_read_a: assert property (REG_RD && REG_ADDR == `TRIM_ADDR_TEMPCO |=>
      REG_RVALID && REG_RDATA == {`TRIM_TEMPCO_PAD, $past(REF_TEMPCO_TRIM)})
    else $error("tempco readback wrong");
  fifo_room_a: assert property (fifo_wr |-> fifo_in_ready)
    else $error("write into full fifo");
endmodule : dual_channel_offset_gain_trim
`default_nettype wire

// File: verilog/trim_defs.svh
// Offsets, reset values, limits and timing counts of the calibration datapath.
// Included by bare name; holds definitions only.
`ifndef TRIM_DEFS_SVH
`define TRIM_DEFS_SVH

`define TRIM_ADDR_W 5
`define TRIM_ADDR_OFF_CH0 5'h0e
`define TRIM_ADDR_GAIN_CH0 5'h11
`define TRIM_ADDR_OFF_CH1 5'h14
`define TRIM_ADDR_GAIN_CH1 5'h17
`define TRIM_ADDR_TEMPCO 5'h1a

`define TRIM_RST_OFF 24'h000000
`define TRIM_RST_GAIN 24'h000000
`define TRIM_RST_TEMPCO 8'h42
`define TRIM_RDATA_ZERO 24'h000000
`define TRIM_TEMPCO_PAD 16'h0000

`define TRIM_CODE_MAX 24'h7fffff
`define TRIM_CODE_MIN 24'h800000
`define TRIM_GAIN_UNITY 25'h0800000
`define TRIM_GAIN_SHIFT 23

`define TRIM_GAIN_DELAY_CYC 24
`define TRIM_FIFO_DEPTH 32
`define TRIM_PAIR_W 48
`define TRIM_CNT_W 7

`endif

// File: verilog/trim_pkg.sv
// Types shared by the calibration datapath files.
// Assumes nothing of its surroundings.
package trim_pkg;
  typedef logic [23:0] code_t;
  typedef logic [47:0] pair_t;
  typedef logic [6:0] count_t;
endpackage : trim_pkg

// File: verilog/sample_fifo.sv
// Parameterised FIFO with a registered output word.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Words held in memory, output word excluded
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [CW-1:0] next_count;
  logic next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic push, pop;

  assign in_ready = (count != CW'(DEPTH));

  always_comb begin
    push = in_valid && in_ready;
    pop = (count != '0) && (!out_valid || out_ready);
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_out_valid = out_valid && !out_ready;
    next_out_data = out_data;
    if (push) begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : AW'(wr_ptr + 1'b1);
    end
    if (pop) begin
      next_out_valid = 1'b1;
      next_out_data = mem[rd_ptr];
      next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : AW'(rd_ptr + 1'b1);
    end
    next_count = CW'(count + CW'(push) - CW'(pop));
  end

  always_ff @(posedge clk) begin
    mem <= next_mem;
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      out_valid <= next_out_valid;
      out_data <= next_out_data;
    end
  end
endmodule : sample_fifo
`default_nettype wire

// File: tb/code_sink.sv
// Sink model standing in for the downstream output path of the trim datapath.
// Assumes the bench drives stall and slow away from the rising edge.
`timescale 1ns/1ps
`default_nettype none
module code_sink (
  // Clock
  input wire logic clk,
  // Pacing control
  input wire logic stall,
  input wire logic slow,
  // Handshake
  output logic ready
);
  logic phase;
  initial begin
    phase = 1'b0;
    ready = 1'b0;
  end
  // Falling edge keeps the handshake clear of the sampling edge
  always @(negedge clk) begin
    phase <= ~phase;
    ready <= !stall && (!slow || phase);
  end
endmodule : code_sink
`default_nettype wire

// File: tb/dual_channel_offset_gain_trim_test.sv
// Self-checking bench for the two-channel offset and gain trim datapath.
// Assumes the design files and the sink model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "trim_defs.svh"
module dual_channel_offset_gain_trim_test;
  logic clk, resetn, reg_wr, reg_rd, reg_rvalid, off_en, gain_en;
  logic in_valid, in_ready, out_valid, out_ready, stall, slow;
  logic [4:0] reg_addr;
  logic [7:0] tempco;
  trim_pkg::code_t reg_wdata, reg_rdata, ch0, ch1, out0, out1;
  int miscompares, checked, cyc, l0, l1, n;
  bit ok;
  logic [4:0] ad [5];
  trim_pkg::code_t wv [5];

  dual_channel_offset_gain_trim dut (
    .CLK_SYS(clk), .RESETN(resetn), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
    .OFFSET_CORRECTION_ENABLE(off_en), .GAIN_CORRECTION_ENABLE(gain_en),
    .CH0_CODE(ch0), .CH1_CODE(ch1), .IN_VALID(in_valid), .IN_READY(in_ready),
    .OUT_CH0(out0), .OUT_CH1(out1), .OUT_VALID(out_valid), .OUT_READY(out_ready),
    .REF_TEMPCO_TRIM(tempco));

  code_sink sink (.clk(clk), .stall(stall), .slow(slow), .ready(out_ready));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Run takes a few hundred cycles; this ceiling only catches a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  task chk(input string nm, input logic [23:0] s, input logic [23:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task wr(input logic [4:0] a, input trim_pkg::code_t d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  task rdc(input logic [4:0] a, input trim_pkg::code_t e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk("reg_rvalid", {23'h000000, reg_rvalid}, 24'h000001);
    chk("reg_rdata", reg_rdata, e);
  endtask : rdc

  // Holds the word until taken; gives up after 40 edges when refused
  task tx(input trim_pkg::code_t a, input trim_pkg::code_t b);
    int w;
    w = 0;
    @(negedge clk);
    ch0 = a;
    ch1 = b;
    in_valid = 1'b1;
    do begin
      @(posedge clk);
      w++;
    end while (in_ready !== 1'b1 && w < 40);
    ok = (in_ready === 1'b1);
    @(negedge clk);
    in_valid = 1'b0;
  endtask : tx

  task rx(input trim_pkg::code_t e0, input trim_pkg::code_t e1);
    int w;
    w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (!(out_valid === 1'b1 && out_ready === 1'b1) && w < 200);
    chk("out_ch0", out0, e0);
    chk("out_ch1", out1, e1);
    // Hand back on a falling edge so callers never drive on the rising one
    @(negedge clk);
  endtask : rx

  // Edges from the take to the first sight of a result
  task lat(output int m);
    m = 1;
    while (out_valid !== 1'b1 && m < 60) begin
      @(negedge clk);
      m++;
    end
  endtask : lat

  task end_of_test();
    $display("Comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  initial begin
    ad = '{`TRIM_ADDR_OFF_CH0, `TRIM_ADDR_GAIN_CH0, `TRIM_ADDR_OFF_CH1, `TRIM_ADDR_GAIN_CH1, `TRIM_ADDR_TEMPCO};
    wv = '{24'h000005, 24'h400000, 24'hfffffd, 24'h7fffff, 24'h00005a};
    {resetn, reg_wr, reg_rd, off_en, gain_en, in_valid, stall, slow} = 8'h00;
    reg_addr = 5'h00;
    reg_wdata = 24'h000000;
    ch0 = 24'h000000;
    ch1 = 24'h000000;
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    for (int i = 0; i < 4; i++) rdc(ad[i], 24'h000000);
    rdc(`TRIM_ADDR_TEMPCO, 24'h000042);
    chk("tempco_pin", {16'h0000, tempco}, 24'h000042);
    rdc(5'h1f, 24'h000000);
    // Tempco written only as a deliberate calibration step
    for (int i = 0; i < 5; i++) wr(ad[i], wv[i]);
    for (int i = 0; i < 5; i++) rdc(ad[i], wv[i]);
    chk("tempco_pin", {16'h0000, tempco}, 24'h00005a);
    off_en = 1'b1;
    tx(24'h000100, 24'h000010);
    lat(l0);
    rx(24'h000105, 24'h00000d);
    tx(24'h7ffffe, 24'h800001);
    rx(24'h7fffff, 24'h800000);
    off_en = 1'b0;
    tx(24'h000100, 24'h000010);
    rx(24'h000100, 24'h000010);
    rdc(`TRIM_ADDR_OFF_CH0, 24'h000005);
    gain_en = 1'b1;
    tx(24'h000100, 24'h000010);
    lat(l1);
    rx(24'h000180, 24'h00001f);
    chk("gain_delay", 24'(l1 - l0), 24'h000018);
    tx(24'h600000, 24'ha00000);
    rx(24'h7fffff, 24'h800000);
    off_en = 1'b1;
    tx(24'h000100, 24'h000010);
    rx(24'h000187, 24'h000019);
    gain_en = 1'b0;
    off_en = 1'b0;
    rdc(`TRIM_ADDR_GAIN_CH0, 24'h400000);
    rdc(`TRIM_ADDR_GAIN_CH1, 24'h7fffff);
    stall = 1'b1;
    n = 0;
    for (int i = 0; i < 40; i++) begin
      tx(24'(i), ~24'(i));
      if (!ok) break;
      n++;
    end
    // Output register holds one word beyond the buffer's depth
    chk("fill_count", 24'(n), 24'(`TRIM_FIFO_DEPTH + 1));
    stall = 1'b0;
    slow = 1'b1;
    for (int i = 0; i < `TRIM_FIFO_DEPTH + 1; i++) rx(24'(i), ~24'(i));
    repeat (4) @(negedge clk);
    chk("out_valid", {23'h000000, out_valid}, 24'h000000);
    end_of_test();
  end
endmodule : dual_channel_offset_gain_trim_test
`default_nettype wire
